// [design/cmc_pkg.sv]
// package of constants and types for the clock and mode control block
package cmc_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [15:0] ADDR_MODE   = 16'h0001;
  localparam logic [15:0] ADDR_DIV    = 16'h0002;
  localparam logic [15:0] ADDR_STATUS = 16'h0003;

  // mode register fields
  localparam int          BIT_BASIC   = 0;
  localparam int          BIT_SCALER  = 1;
  localparam int          BIT_ENHANCE = 2;
  localparam int          BIT_OVERLAY = 3;
  localparam int          BIT_VIDEO   = 4;
  localparam logic [6:0]  MODE_RST    = 7'h00;
  localparam logic [7:0]  DIV_RST     = 8'h01;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int          SYS_CLK_MHZ  = 100;
  localparam int          XTAL_NOM_MHZ = 25;
  // system cycles per crystal period, rounded down
  localparam int          XTAL_SYS_CYC = SYS_CLK_MHZ / XTAL_NOM_MHZ;

  // gated clock indices
  localparam int          GC_BASIC   = 0;
  localparam int          GC_SCALER  = 1;
  localparam int          GC_ENHANCE = 2;
  localparam int          GC_OVERLAY = 3;
  localparam int          GC_DEINT   = 4;
  localparam int          GC_NUM     = 5;

  // pin sampler indices
  localparam int          PIN_RGB  = 0;
  localparam int          PIN_VID  = 1;
  localparam int          PIN_XTAL = 2;

  // operating mode shown in status
  typedef enum logic [2:0] {
    CMC_OP_STANDBY   = 3'b000,
    CMC_OP_PASS      = 3'b001,
    CMC_OP_PASS_OVL  = 3'b010,
    CMC_OP_PASS_ENH  = 3'b011,
    CMC_OP_SCALE_RGB = 3'b100,
    CMC_OP_VIDEO     = 3'b101,
    CMC_OP_OTHER     = 3'b110
  } cmc_op_t;

  // host presets
  typedef enum logic [2:0] {
    CMC_PRE_DPMS   = 3'b000,
    CMC_PRE_BYP1   = 3'b001,
    CMC_PRE_BYP2   = 3'b010,
    CMC_PRE_BYP3   = 3'b011,
    CMC_PRE_SCALE1 = 3'b100,
    CMC_PRE_SCALE2 = 3'b101,
    CMC_PRE_SCALE3 = 3'b110,
    CMC_PRE_SCALE4 = 3'b111
  } cmc_preset_t;

endpackage

// [design/cmc_if.sv]
// interface between the host end and the device end
`timescale 1ns/1ps
interface cmc_if;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic        reg_rvalid;
  logic        host_if_select;
  logic        serial_host_en;
  logic        host_chip_sel_n;
  logic        scan_en;
  logic        test_mode_sel0;
  logic        test_mode_sel1;

  modport dev (
    input  reg_wr, reg_rd, reg_addr, reg_wdata,
    input  host_if_select, serial_host_en, host_chip_sel_n,
    input  scan_en, test_mode_sel0, test_mode_sel1,
    output reg_rdata, reg_rvalid
  );

  modport host (
    output reg_wr, reg_rd, reg_addr, reg_wdata,
    output host_if_select, serial_host_en, host_chip_sel_n,
    output scan_en, test_mode_sel0, test_mode_sel1,
    input  reg_rdata, reg_rvalid
  );
endinterface

// [design/cmc_device.sv]
// device end: clock selection, block clock gating and mode register
`timescale 1ns/1ps
module cmc_device (
  input  wire logic clk_sys,
  input  wire logic sys_rst_n,
  cmc_if.dev        bus,
  input  wire logic rgb_in_clk,
  input  wire logic video_in_clk,
  input  wire logic xtal_ref_clk,
  output logic      in_path_clk,
  output logic      scaler_clk,
  output logic      enhance_clk,
  output logic      overlay_clk,
  output logic      deint_clk,
  output logic      host_if_clk,
  output logic      panel_pixel_clk_out,
  output logic      scaled_out_clk,
  output logic      video_sel,
  output logic [2:0] op_mode
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [6:0]        mode_q,   mode_d;
  logic [7:0]        div_q,    div_d;
  logic [7:0]        rdata_q,  rdata_d;
  logic              rvalid_q, rvalid_d;
  localparam int     GC_NUM_W = cmc_pkg::GC_NUM - 1;
  logic [2:0]        s1_q, s2_q, s3_q, lvl_q, lvl_d;
  logic [GC_NUM_W:0] en_q,   en_d;
  logic [GC_NUM_W:0] gclk_q, gclk_d;
  logic              sel_q,  sel_d;
  logic [7:0]        cnt_q,  cnt_d;
  logic              pclk_q, pclk_d;
  logic              xclk_q, xclk_d;
  cmc_pkg::cmc_op_t  op_q,   op_d;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // decode of the enable bits into an operating mode
  function automatic cmc_pkg::cmc_op_t op_decode(input logic [6:0] m);
    logic b;
    logic s;
    logic e;
    logic o;
    logic v;
    b = m[cmc_pkg::BIT_BASIC];
    s = m[cmc_pkg::BIT_SCALER];
    e = m[cmc_pkg::BIT_ENHANCE];
    o = m[cmc_pkg::BIT_OVERLAY];
    v = m[cmc_pkg::BIT_VIDEO];
    if (!b) begin
      op_decode = cmc_pkg::CMC_OP_STANDBY;
    end else if (v) begin
      op_decode = cmc_pkg::CMC_OP_VIDEO;
    end else if (s && e && o) begin
      op_decode = cmc_pkg::CMC_OP_SCALE_RGB;
    end else if (!s && !e && o) begin
      op_decode = cmc_pkg::CMC_OP_PASS_OVL;
    end else if (!s && e && !o) begin
      op_decode = cmc_pkg::CMC_OP_PASS_ENH;
    end else if (!s && !e && !o) begin
      op_decode = cmc_pkg::CMC_OP_PASS;
    end else begin
      op_decode = cmc_pkg::CMC_OP_OTHER;
    end
  endfunction

  // ---------------------------------------------------------------
  // pin samplers
  // ---------------------------------------------------------------
  // three stages, level moves only when stages two and three agree
  always_comb begin
    lvl_d = lvl_q;
    for (int i = 0; i < 3; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        lvl_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      s1_q  <= 3'h0;
      s2_q  <= 3'h0;
      s3_q  <= 3'h0;
      lvl_q <= 3'h0;
    end else begin
      s1_q  <= {xtal_ref_clk, video_in_clk, rgb_in_clk};
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  // ---------------------------------------------------------------
  // register access
  // ---------------------------------------------------------------
  logic acc_ok;
  logic xtal_rise;
  logic standby;
  logic src_lvl;
  logic want_sel;
  logic [GC_NUM_W:0] want;

  assign acc_ok = bus.host_if_select && bus.serial_host_en && bus.host_chip_sel_n &&
                  !bus.scan_en && !bus.test_mode_sel0 && !bus.test_mode_sel1;

  always_comb begin
    mode_d   = mode_q;
    div_d    = div_q;
    rdata_d  = 8'h00;
    rvalid_d = bus.reg_rd && acc_ok;
    if (bus.reg_wr && acc_ok) begin
      unique case (bus.reg_addr)
        cmc_pkg::ADDR_MODE: mode_d = bus.reg_wdata[6:0];
        cmc_pkg::ADDR_DIV:  div_d  = bus.reg_wdata;
        default:            mode_d = mode_q;
      endcase
    end
    if (bus.reg_rd && acc_ok) begin
      unique case (bus.reg_addr)
        cmc_pkg::ADDR_MODE:   rdata_d = {1'b0, mode_q};
        cmc_pkg::ADDR_DIV:    rdata_d = div_q;
        cmc_pkg::ADDR_STATUS: rdata_d = {en_q, op_q};
        default:              rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      mode_q   <= cmc_pkg::MODE_RST;
      div_q    <= cmc_pkg::DIV_RST;
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      mode_q   <= mode_d;
      div_q    <= div_d;
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // ---------------------------------------------------------------
  // block clock gating
  // ---------------------------------------------------------------
  // basic bit low means standby
  assign standby  = !mode_q[cmc_pkg::BIT_BASIC];
  assign want_sel = mode_q[cmc_pkg::BIT_VIDEO];
  // input path source follows video select
  assign src_lvl  = sel_q ? lvl_q[cmc_pkg::PIN_VID] : lvl_q[cmc_pkg::PIN_RGB];

  always_comb begin
    want = '0;
    if (!standby && (sel_q == want_sel)) begin
      want[cmc_pkg::GC_BASIC]   = 1'b1;
      want[cmc_pkg::GC_SCALER]  = mode_q[cmc_pkg::BIT_SCALER];
      want[cmc_pkg::GC_ENHANCE] = mode_q[cmc_pkg::BIT_ENHANCE];
      want[cmc_pkg::GC_OVERLAY] = mode_q[cmc_pkg::BIT_OVERLAY];
      want[cmc_pkg::GC_DEINT]   = mode_q[cmc_pkg::BIT_VIDEO];
    end
    // enables move only while source is low
    en_d = en_q;
    if (!src_lvl && (gclk_q == '0)) begin
      en_d = want;
    end
    // source switch only with every gate closed
    sel_d = sel_q;
    if ((en_q == '0) && (gclk_q == '0) && (want == '0)) begin
      sel_d = want_sel;
    end
    for (int i = 0; i < cmc_pkg::GC_NUM; i++) begin
      gclk_d[i] = src_lvl && en_q[i];
    end
    op_d = op_decode(mode_q);
  end

  always_ff @(posedge clk_sys or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      en_q   <= '0;
      gclk_q <= '0;
      sel_q  <= 1'b0;
      op_q   <= cmc_pkg::CMC_OP_STANDBY;
    end else begin
      en_q   <= en_d;
      gclk_q <= gclk_d;
      sel_q  <= sel_d;
      op_q   <= op_d;
    end
  end

  // ---------------------------------------------------------------
  // pixel clock from crystal
  // ---------------------------------------------------------------
  assign xtal_rise = lvl_d[cmc_pkg::PIN_XTAL] && !lvl_q[cmc_pkg::PIN_XTAL];

  // toggle pixel clock every div_q rising crystal edges, every rising edge when div_q is 0
  always_comb begin
    cnt_d  = cnt_q;
    pclk_d = pclk_q;
    xclk_d = lvl_q[cmc_pkg::PIN_XTAL];
    if (standby) begin
      cnt_d  = 8'h00;
      pclk_d = 1'b0;
    end else if (xtal_rise) begin
      if ((cnt_q + 8'h01) >= div_q) begin
        cnt_d  = 8'h00;
        pclk_d = !pclk_q;
      end else begin
        cnt_d  = cnt_q + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      cnt_q  <= 8'h00;
      pclk_q <= 1'b0;
      xclk_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      pclk_q <= pclk_d;
      xclk_q <= xclk_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign bus.reg_rdata       = rdata_q;
  assign bus.reg_rvalid      = rvalid_q;
  assign in_path_clk         = gclk_q[cmc_pkg::GC_BASIC];
  assign scaler_clk          = gclk_q[cmc_pkg::GC_SCALER];
  assign enhance_clk         = gclk_q[cmc_pkg::GC_ENHANCE];
  assign overlay_clk         = gclk_q[cmc_pkg::GC_OVERLAY];
  assign deint_clk           = gclk_q[cmc_pkg::GC_DEINT];
  assign host_if_clk         = xclk_q;
  assign panel_pixel_clk_out = pclk_q;
  assign scaled_out_clk      = pclk_q;
  assign video_sel           = sel_q;
  assign op_mode             = op_q;

endmodule

// [design/cmc_host.sv]
// host end: programs mode presets and pixel divider, reads status
`timescale 1ns/1ps
module cmc_host (
  input  wire logic                 clk_sys,
  input  wire logic                 sys_rst_n,
  cmc_if.host                       bus,
  input  wire cmc_pkg::cmc_preset_t preset,
  input  wire logic                 preset_go,
  input  wire logic [7:0]           div_val,
  input  wire logic                 div_go,
  input  wire logic                 status_go,
  input  wire logic                 autotune_req,
  output logic                      autotune_grant,
  output logic                      autotune_refused,
  output logic                      busy,
  output logic [7:0]                status,
  output logic                      status_valid
);

  typedef enum logic [1:0] {
    CMC_H_IDLE = 2'b00,
    CMC_H_WAIT = 2'b01
  } cmc_hstate_t;

  cmc_hstate_t st_q, st_d;
  logic        wr_q, wr_d, rd_q, rd_d;
  logic [15:0] addr_q, addr_d;
  logic [7:0]  wdata_q, wdata_d;
  logic [6:0]  cur_q, cur_d;
  logic [7:0]  stat_q, stat_d;
  logic        sv_q, sv_d, gr_q, gr_d, rf_q, rf_d;
  logic        busy_q, busy_d;

  // ---------------------------------------------------------------
  // preset table
  // ---------------------------------------------------------------
  // bits {video, overlay, enhance, scaler, basic}
  function automatic logic [6:0] preset_bits(input cmc_pkg::cmc_preset_t p);
    unique case (p)
      cmc_pkg::CMC_PRE_DPMS:   preset_bits = 7'h00;
      cmc_pkg::CMC_PRE_BYP1:   preset_bits = 7'h01;
      cmc_pkg::CMC_PRE_BYP2:   preset_bits = 7'h09;
      cmc_pkg::CMC_PRE_BYP3:   preset_bits = 7'h05;
      cmc_pkg::CMC_PRE_SCALE1: preset_bits = 7'h0F;
      cmc_pkg::CMC_PRE_SCALE2: preset_bits = 7'h1B;
      cmc_pkg::CMC_PRE_SCALE3: preset_bits = 7'h17;
      cmc_pkg::CMC_PRE_SCALE4: preset_bits = 7'h1F;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // request sequencer
  // ---------------------------------------------------------------
  always_comb begin
    st_d    = st_q;
    wr_d    = 1'b0;
    rd_d    = 1'b0;
    addr_d  = addr_q;
    wdata_d = wdata_q;
    cur_d   = cur_q;
    stat_d  = stat_q;
    sv_d    = 1'b0;
    // no auto tuning while video path is on
    gr_d    = autotune_req && !cur_q[cmc_pkg::BIT_VIDEO];
    rf_d    = autotune_req && cur_q[cmc_pkg::BIT_VIDEO];
    unique case (st_q)
      CMC_H_IDLE: begin
        if (preset_go) begin
          // presets keep basic bit outside standby
          wr_d    = 1'b1;
          addr_d  = cmc_pkg::ADDR_MODE;
          wdata_d = {1'b0, preset_bits(preset)};
          cur_d   = preset_bits(preset);
        end else if (div_go) begin
          wr_d    = 1'b1;
          addr_d  = cmc_pkg::ADDR_DIV;
          wdata_d = div_val;
        end else if (status_go) begin
          rd_d    = 1'b1;
          addr_d  = cmc_pkg::ADDR_STATUS;
          st_d    = CMC_H_WAIT;
        end
      end
      CMC_H_WAIT: begin
        if (bus.reg_rvalid) begin
          stat_d = bus.reg_rdata;
          sv_d   = 1'b1;
          st_d   = CMC_H_IDLE;
        end
      end
      default: st_d = CMC_H_IDLE;
    endcase
    // busy while a status read is outstanding
    busy_d  = (st_d != CMC_H_IDLE);
  end

  always_ff @(posedge clk_sys or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      st_q    <= CMC_H_IDLE;
      wr_q    <= 1'b0;
      rd_q    <= 1'b0;
      addr_q  <= 16'h0000;
      wdata_q <= 8'h00;
      cur_q   <= cmc_pkg::MODE_RST;
      stat_q  <= 8'h00;
      sv_q    <= 1'b0;
      gr_q    <= 1'b0;
      rf_q    <= 1'b0;
      busy_q  <= 1'b0;
    end else begin
      st_q    <= st_d;
      wr_q    <= wr_d;
      rd_q    <= rd_d;
      addr_q  <= addr_d;
      wdata_q <= wdata_d;
      cur_q   <= cur_d;
      stat_q  <= stat_d;
      sv_q    <= sv_d;
      gr_q    <= gr_d;
      rf_q    <= rf_d;
      busy_q  <= busy_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // strap levels for two-wire access
  assign bus.host_if_select  = 1'b1;
  assign bus.serial_host_en  = 1'b1;
  assign bus.host_chip_sel_n = 1'b1;
  assign bus.scan_en         = 1'b0;
  assign bus.test_mode_sel0  = 1'b0;
  assign bus.test_mode_sel1  = 1'b0;
  assign bus.reg_wr          = wr_q;
  assign bus.reg_rd          = rd_q;
  assign bus.reg_addr        = addr_q;
  assign bus.reg_wdata       = wdata_q;
  assign autotune_grant      = gr_q;
  assign autotune_refused    = rf_q;
  assign busy                = busy_q;
  assign status              = stat_q;
  assign status_valid        = sv_q;

endmodule

// [verification/cmc_asserts.sv]
// concurrent checks on the bus joining the host and device ends
`timescale 1ns/1ps
module cmc_asserts (
  input wire logic        clk_sys,
  input wire logic        sys_rst_n,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  input wire logic        reg_rvalid,
  input wire logic        host_if_select,
  input wire logic        serial_host_en,
  input wire logic        host_chip_sel_n,
  input wire logic        scan_en,
  input wire logic        test_mode_sel0,
  input wire logic        test_mode_sel1
);
  logic [6:0] mode_q;
  logic [6:0] mode_d;
  logic       st_rd;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!sys_rst_n);

  // shadow of the mode register as written
  always_comb begin
    mode_d = mode_q;
    if (reg_wr && reg_addr == cmc_pkg::ADDR_MODE) begin
      mode_d = reg_wdata[6:0];
    end
  end
  always_ff @(posedge clk_sys or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      mode_q <= cmc_pkg::MODE_RST;
    end else begin
      mode_q <= mode_d;
    end
  end
  assign st_rd = reg_rvalid;

  a_read_answered: assert property (reg_rd |=> reg_rvalid)
    else $error("read strobe without answer");
  a_answer_cause: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("read answer without request");
  a_status_enables: assert property (st_rd && $past(reg_addr) == cmc_pkg::ADDR_STATUS
    |-> reg_rdata[7:3] == mode_q[4:0])
    else $error("status enables differ from mode");
  a_standby_status: assert property (st_rd && $past(reg_addr) == cmc_pkg::ADDR_STATUS
    && !mode_q[0] |-> reg_rdata[2:0] == cmc_pkg::CMC_OP_STANDBY)
    else $error("standby not reported");
  a_video_mode: assert property (st_rd && $past(reg_addr) == cmc_pkg::ADDR_STATUS
    && mode_q[0] && mode_q[4] |-> reg_rdata[2:0] == cmc_pkg::CMC_OP_VIDEO)
    else $error("video mode not reported");
  a_full_scale: assert property (st_rd && $past(reg_addr) == cmc_pkg::ADDR_STATUS
    && mode_q[4:0] == 5'h0F |-> reg_rdata[2:0] == cmc_pkg::CMC_OP_SCALE_RGB)
    else $error("full scaling not reported");
  a_overlay_pass: assert property (st_rd && $past(reg_addr) == cmc_pkg::ADDR_STATUS
    && mode_q[4:0] == 5'h09 |-> reg_rdata[2:0] == cmc_pkg::CMC_OP_PASS_OVL)
    else $error("overlay pass not reported");
  a_basic_kept: assert property (reg_wr && reg_addr == cmc_pkg::ADDR_MODE
    && reg_wdata != 8'h00 |-> reg_wdata[0])
    else $error("mode written without basic bit");
  a_straps_high: assert property (host_if_select && serial_host_en
    && host_chip_sel_n)
    else $error("host select straps not high");
  a_test_low: assert property (!scan_en && !test_mode_sel0 && !test_mode_sel1)
    else $error("test pins not low");
endmodule

// [verification/clock_and_mode_control_tb.sv]
// self-checking bench joining the host end to the device end
`timescale 1ns/1ps
module clock_and_mode_control_tb;
  logic clk_sys, sys_rst_n, rgb_in_clk, video_in_clk, xtal_ref_clk;
  logic in_path_clk, scaler_clk, enhance_clk, overlay_clk, deint_clk, host_if_clk;
  logic panel_pixel_clk_out, scaled_out_clk, video_sel;
  logic [2:0] op_mode;
  cmc_pkg::cmc_preset_t preset;
  logic preset_go, div_go, status_go, autotune_req, busy, status_valid;
  logic autotune_grant, autotune_refused;
  logic [7:0] div_val, status, st;
  logic [6:0] mode_m;
  logic [7:0] exp_q [$];
  logic [7:0] pre_tab [8] = '{8'h00, 8'h01, 8'h09, 8'h05, 8'h0F, 8'h1B, 8'h17, 8'h1F};
  int check_count, fail_count, seed, div_m, gr, rf, src;
  int cnt [8];

  cmc_if bus ();
  cmc_device cmc_device_inst (.clk_sys(clk_sys), .sys_rst_n(sys_rst_n), .bus(bus.dev),
    .rgb_in_clk(rgb_in_clk), .video_in_clk(video_in_clk), .xtal_ref_clk(xtal_ref_clk),
    .in_path_clk(in_path_clk), .scaler_clk(scaler_clk), .enhance_clk(enhance_clk),
    .overlay_clk(overlay_clk), .deint_clk(deint_clk), .host_if_clk(host_if_clk),
    .panel_pixel_clk_out(panel_pixel_clk_out), .scaled_out_clk(scaled_out_clk),
    .video_sel(video_sel), .op_mode(op_mode));
  cmc_host cmc_host_inst (.clk_sys(clk_sys), .sys_rst_n(sys_rst_n), .bus(bus.host),
    .preset(preset), .preset_go(preset_go), .div_val(div_val), .div_go(div_go),
    .status_go(status_go), .autotune_req(autotune_req), .autotune_grant(autotune_grant),
    .autotune_refused(autotune_refused), .busy(busy), .status(status),
    .status_valid(status_valid));
  cmc_asserts cmc_asserts_inst (.clk_sys(clk_sys), .sys_rst_n(sys_rst_n),
    .reg_wr(bus.reg_wr), .reg_rd(bus.reg_rd), .reg_addr(bus.reg_addr),
    .reg_wdata(bus.reg_wdata), .reg_rdata(bus.reg_rdata), .reg_rvalid(bus.reg_rvalid),
    .host_if_select(bus.host_if_select), .serial_host_en(bus.serial_host_en),
    .host_chip_sel_n(bus.host_chip_sel_n), .scan_en(bus.scan_en),
    .test_mode_sel0(bus.test_mode_sel0), .test_mode_sel1(bus.test_mode_sel1));

  // system clock and unrelated pin clocks
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always #30 rgb_in_clk = ~rgb_in_clk;
  always #42 video_in_clk = ~video_in_clk;
  always #20 xtal_ref_clk = ~xtal_ref_clk;

  // rising edge counters of every produced clock
  always @(posedge in_path_clk) cnt[0]++;
  always @(posedge scaler_clk) cnt[1]++;
  always @(posedge enhance_clk) cnt[2]++;
  always @(posedge overlay_clk) cnt[3]++;
  always @(posedge deint_clk) cnt[4]++;
  always @(posedge host_if_clk) cnt[5]++;
  always @(posedge panel_pixel_clk_out) cnt[6]++;
  always @(posedge scaled_out_clk) cnt[7]++;
  always @(posedge clk_sys) begin
    if (autotune_grant === 1'b1) gr++;
    if (autotune_refused === 1'b1) rf++;
  end

  task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic check_near(input int got, input int exp);
    check_count++;
    if (got > exp + 1 || got < exp - 1) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic pulse(ref logic s);
    @(negedge clk_sys);
    s = 1'b1;
    @(negedge clk_sys);
    s = 1'b0;
  endtask

  task automatic read_status();
    pulse(status_go);
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_sys);
      #1;
      if (i == 0) check_val({7'h00, busy}, 8'h01);
      if (status_valid === 1'b1) begin
        st = status;
        check_val({7'h00, busy}, 8'h00);
        return;
      end
    end
    fail_count++;
    finish_test();
  endtask

  // model of operating mode from the enable bits
  function automatic logic [2:0] exp_op(input logic [6:0] m);
    if (!m[0]) return 3'h0;
    if (m[4]) return 3'h5;
    if (m[3:1] == 3'b111) return 3'h4;
    if (m[3:1] == 3'b100) return 3'h2;
    if (m[3:1] == 3'b010) return 3'h3;
    if (m[3:1] == 3'b000) return 3'h1;
    return 3'h6;
  endfunction

  // count edges over 1680 ns and compare with the model
  task automatic measure();
    cnt = '{default: 0};
    repeat (168) @(posedge clk_sys);
    src = mode_m[4] ? 20 : 28;
    check_near(cnt[0], mode_m[0] ? src : 0);
    check_near(cnt[1], (mode_m[0] && mode_m[1]) ? src : 0);
    check_near(cnt[2], (mode_m[0] && mode_m[2]) ? src : 0);
    check_near(cnt[3], (mode_m[0] && mode_m[3]) ? src : 0);
    check_near(cnt[4], (mode_m[0] && mode_m[4]) ? src : 0);
    check_near(cnt[5], 42);
    check_near(cnt[6], mode_m[0] ? 42 / (2 * div_m) : 0);
    check_near(cnt[7], mode_m[0] ? 42 / (2 * div_m) : 0);
  endtask

  task automatic run_preset(input int p);
    @(negedge clk_sys);
    preset = cmc_pkg::cmc_preset_t'(p[2:0]);
    pulse(preset_go);
    mode_m = pre_tab[p][6:0];
    repeat (30) @(posedge clk_sys);
    #1;
    check_val({5'h00, op_mode}, {5'h00, exp_op(mode_m)});
    check_val({7'h00, video_sel}, {7'h00, mode_m[4]});
    exp_q.push_back({mode_m[4:0], exp_op(mode_m)});
    read_status();
    check_val(st, exp_q.pop_front());
    gr = 0;
    rf = 0;
    pulse(autotune_req);
    repeat (4) @(posedge clk_sys);
    check_val(gr[7:0], {7'h00, !mode_m[4]});
    check_val(rf[7:0], {7'h00, mode_m[4]});
    measure();
  endtask

  task automatic do_reset();
    @(negedge clk_sys);
    sys_rst_n = 1'b0;
    repeat (20) @(negedge clk_sys);
    sys_rst_n = 1'b1;
    mode_m = 7'h00;
    div_m = 1;
  endtask

  // main sequence
  initial begin
    seed = 43063;
    sys_rst_n = 1'b0;
    rgb_in_clk = 1'b0;
    video_in_clk = 1'b0;
    xtal_ref_clk = 1'b0;
    preset = cmc_pkg::CMC_PRE_DPMS;
    {preset_go, div_go, status_go, autotune_req} = 4'h0;
    div_val = 8'h00;
    do_reset();
    #1;
    check_val({5'h00, op_mode}, 8'h00);
    measure();
    $display("test reset done");
    for (int p = 0; p < 8; p++) run_preset(p);
    $display("test presets done");
    for (int k = 0; k < 4; k++) begin
      div_m = $unsigned($random(seed)) % 4;
      @(negedge clk_sys);
      div_val = div_m[7:0];
      pulse(div_go);
      if (div_m == 0) div_m = 1;
      run_preset($unsigned($random(seed)) % 8);
    end
    $display("test divider done");
    do_reset();
    read_status();
    check_val(st, 8'h00);
    $display("test second reset done");
    finish_test();
  end
endmodule
